// File: rtl/bds_pkg.sv
// Purpose: shared constants and types for the burst-of-four split-port ddr sram
// Assumes: core clock of 10 ns drives command and data timing
// Notes:   data widths are sized for the 36-bit configuration, address width for the 18-bit; the other uses the low part
package bds_pkg;

  // geometry
  localparam int DATA_W        = 36;
  localparam int DATA_W_NARROW = 18;
  localparam int LANE_W        = 9;
  localparam int LANES         = 4;
  localparam int LANES_NARROW  = 2;
  localparam int BURST_LEN     = 4;
  localparam int ADDR_W        = 19;
  localparam int ADDR_W_WIDE   = 18;
  localparam int ROW_W         = DATA_W * BURST_LEN;
  localparam int ROW_LANES     = LANES * BURST_LEN;
  localparam int ROW_DEPTH     = 1 << ADDR_W;

  // lane masks per configuration
  localparam logic [LANES-1:0] LANE_MASK_WIDE   = 4'hf;
  localparam logic [LANES-1:0] LANE_MASK_NARROW = 4'h3;

  // timing
  localparam int CLOCK_PERIOD_NS  = 10;
  localparam int MODE_HOLD_NS     = 200;
  localparam int MODE_HOLD_CYCLES = (MODE_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DLL_LOCK_CYCLES  = 1024;
  localparam int HOLD_CNT_W       = 8;
  localparam int LOCK_CNT_W       = 11;
  localparam logic [HOLD_CNT_W-1:0] HOLD_CNT_MAX = HOLD_CNT_W'(MODE_HOLD_CYCLES);
  localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_MAX = LOCK_CNT_W'(DLL_LOCK_CYCLES);

  // values after reset
  localparam logic RST_SINGLE_MODE = 1'b1;
  localparam logic RST_PREV_NOP    = 1'b1;
  localparam logic RST_PIN_HIGH    = 1'b1; // idle level of parked output clock and loop pin

  // one buffered write burst
  typedef struct packed {
    logic                                valid;
    logic [ADDR_W-1:0]                   addr;
    logic [BURST_LEN-1:0][DATA_W-1:0]    data;
    logic [BURST_LEN-1:0][LANES-1:0]     lane_en;
  } bds_entry_t;

  // one output data beat
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              valid;
  } bds_beat_t;

  // output-clock domain burst sequencer
  typedef enum logic [2:0] {
    BDS_C_IDLE   = 3'b001,
    BDS_C_FIRST  = 3'b010,
    BDS_C_SECOND = 3'b100
  } bds_cstate_t;

endpackage

// File: rtl/bds_row_mem.sv
// Purpose: storage array, one row holds a whole burst of four words
// Assumes: single clock, read data registered, per-lane write enables
// Notes:   no reset on the array; contents are undefined at power-up
`timescale 1ns/1ps
`default_nettype none
module bds_row_mem
  import bds_pkg::*;
(
  // clock
  input  wire logic                         clock,
  // read port
  input  wire logic                         rd_en,
  input  wire logic [ADDR_W-1:0]            rd_addr,
  output logic      [ROW_W-1:0]             rd_row,
  // write port
  input  wire logic                         wr_en,
  input  wire logic [ADDR_W-1:0]            wr_addr,
  input  wire logic [ROW_W-1:0]             wr_row,
  input  wire logic [ROW_LANES-1:0]         wr_lane
);

  logic [ROW_W-1:0] mem [ROW_DEPTH];

  // lane-gated write, read-before-write on a shared row
  always_ff @(posedge clock) begin
    if (wr_en) begin
      for (int i = 0; i < ROW_LANES; i++) begin
        if (wr_lane[i]) begin
          mem[wr_addr][i*LANE_W +: LANE_W] <= wr_row[i*LANE_W +: LANE_W];
        end
      end
    end
    if (rd_en) begin
      rd_row <= mem[rd_addr];
    end
  end

endmodule
`default_nettype wire

// File: rtl/bds_sram.sv
// Purpose: burst-of-four split-port ddr sram core with late write and echo strobes
// Assumes: clock is the true input clock; its falling edge stands for the
//          complement input clock rising edge, likewise for out_clock
// Notes:   output-clock mode drops a read that arrives while a hand-off is open
// Function
// - read burst starts when read_n is low at a true-clock rising edge
// - toggling output clock times the read data outputs
// - free-running echo strobe pair follows the read data transitions
// - output clocks held high: read data timed from input clocks
// - single-clock mode: first read word at t+1.5 on complement edge
// - second word at t+2, third and fourth on following edges
// - a no-operation cycle never cuts a running read burst short
// - write burst starts on write_n low; at most every other edge
// - every write moves exactly four words to consecutive locations
// - first write word captured one cycle after the command
// - words two to four captured on alternating following edges
// - dll_off_n low bypasses the delay-locked loop
// - write_n high means no write on that edge
// - 36-bit configuration has four active-low byte lane enables
// - 18-bit configuration has two active-low byte lane enables
// - 36-bit configuration has separate 36-bit data in and out
// - 18-bit configuration has separate 18-bit data in and out
// - second of two back-to-back reads or writes is ignored
// - read and write together after a no-operation: write ignored
// - burst addressing is linear from the base address
// - reads of the last two written bursts return buffered data
`timescale 1ns/1ps
`default_nettype none
module bds_sram
  import bds_pkg::*;
#(
  parameter bit WIDE_CONFIG = 1'b1
)
(
  // core clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_b,
  // output timing clock
  input  wire logic                   out_clock,
  // commands
  input  wire logic                   read_n,
  input  wire logic                   write_n,
  input  wire logic [ADDR_W-1:0]      burst_base_address,
  // write data
  input  wire logic [LANES-1:0]       byte_lane_enable_n,
  input  wire logic [DATA_W-1:0]      write_data,
  // read data
  output logic      [DATA_W-1:0]      read_data,
  output logic                        read_valid,
  output logic                        echo_strobe,
  output logic                        echo_strobe_n,
  // loop and mode status
  input  wire logic                   dll_off_n,
  output logic                        dll_locked,
  output logic                        dll_bypass,
  output logic                        single_clock_mode
);

  // unused upper lanes are never write-enabled in the narrow part; the top address bit reads as zero in the wide part
  function automatic logic [LANES-1:0] lane_mask(input logic [LANES-1:0] en_n);
    lane_mask = ~en_n & (WIDE_CONFIG ? LANE_MASK_WIDE : LANE_MASK_NARROW);
  endfunction

  // overlay one buffered burst onto a row if it targets the same base
  function automatic logic [ROW_W-1:0] merge_entry(input logic [ROW_W-1:0] row,
                                                   input bds_entry_t e,
                                                   input logic [ADDR_W-1:0] addr);
    merge_entry = row;
    for (int w = 0; w < BURST_LEN; w++) begin
      for (int l = 0; l < LANES; l++) begin
        if (e.valid && e.addr == addr && e.lane_en[w][l]) begin
          merge_entry[w*DATA_W + l*LANE_W +: LANE_W] = e.data[w][l*LANE_W +: LANE_W];
        end
      end
    end
  endfunction

  logic [ADDR_W-1:0]    addr_eff;
  logic [DATA_W-1:0]    wdata_eff;
  logic                 rd_acc, wr_acc;
  logic                 rd_p1, rd_p2, rd_p3;
  logic                 wr_p1, wr_p2, wr_p3;
  logic                 prev_nop;
  logic [ADDR_W-1:0]    rd_addr_q;
  logic [ADDR_W-1:0]    wr_addr_q, wr_addr_q2;
  logic [DATA_W-1:0]    w0, w1, w2, w3;
  logic [LANES-1:0]     e0, e1, e2, e3;
  bds_entry_t           incoming, buf0, buf1, retire;
  logic [ROW_W-1:0]     mem_row, merged_row, rd_row, xfer_row;
  logic                 xfer_req, ack_s1, ack_s2;
  bds_beat_t            k_pos, k_neg, c_pos, c_neg, beat;
  logic                 oc_s1, oc_s2, oc_s3;
  logic [HOLD_CNT_W-1:0] hold_cnt;
  logic                 doff_s1, doff_s2;
  logic [LOCK_CNT_W-1:0] lock_cnt;
  logic                 crst_s1, c_rst_b;
  logic                 req_s1, req_s2, c_ack;
  logic [ROW_W-1:0]     c_row;
  bds_cstate_t          c_state;

  // narrow configuration uses 19 address bits and 18 data bits
  assign addr_eff  = WIDE_CONFIG ? {1'b0, burst_base_address[ADDR_W_WIDE-1:0]}
                                 : burst_base_address;
  assign wdata_eff = WIDE_CONFIG ? write_data
                                 : {{(DATA_W-DATA_W_NARROW){1'b0}},
                                    write_data[DATA_W_NARROW-1:0]};

  // command acceptance at the true-clock rising edge
  assign rd_acc = !read_n && !rd_p1;
  assign wr_acc = !write_n && !wr_p1 && !(rd_acc && prev_nop);

  // burst phase pipelines keep running whatever the next command is
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rd_p1    <= 1'b0;
      rd_p2    <= 1'b0;
      rd_p3    <= 1'b0;
      wr_p1    <= 1'b0;
      wr_p2    <= 1'b0;
      wr_p3    <= 1'b0;
      prev_nop <= RST_PREV_NOP;
    end else begin
      rd_p1    <= rd_acc;
      rd_p2    <= rd_p1;
      rd_p3    <= rd_p2;
      wr_p1    <= wr_acc;
      wr_p2    <= wr_p1;
      wr_p3    <= wr_p2;
      prev_nop <= read_n && write_n;
    end
  end

  // addresses taken on the accepting edge; write address kept for assembly
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rd_addr_q  <= '0;
      wr_addr_q  <= '0;
      wr_addr_q2 <= '0;
    end else begin
      if (rd_acc) begin
        rd_addr_q <= addr_eff;
      end
      if (wr_acc) begin
        wr_addr_q <= addr_eff;
      end
      wr_addr_q2 <= wr_addr_q;
    end
  end

  // late write: words one and three on true-clock rising edges
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      w0 <= '0;
      w2 <= '0;
      e0 <= '0;
      e2 <= '0;
    end else begin
      if (wr_p1) begin
        w0 <= wdata_eff;
        e0 <= lane_mask(byte_lane_enable_n);
      end
      if (wr_p2) begin
        w2 <= wdata_eff;
        e2 <= lane_mask(byte_lane_enable_n);
      end
    end
  end

  // words two and four on the complement-clock rising edge
  always_ff @(negedge clock) begin
    if (!rst_b) begin
      w1 <= '0;
      w3 <= '0;
      e1 <= '0;
      e3 <= '0;
    end else begin
      if (wr_p2) begin
        w1 <= wdata_eff;
        e1 <= lane_mask(byte_lane_enable_n);
      end
      if (wr_p3) begin
        w3 <= wdata_eff;
        e3 <= lane_mask(byte_lane_enable_n);
      end
    end
  end

  // complete burst, word index is the linear offset from the base
  always_comb begin
    incoming.valid   = wr_p3;
    incoming.addr    = wr_addr_q2;
    incoming.data    = {w3, w2, w1, w0};
    incoming.lane_en = {e3, e2, e1, e0};
  end

  // two-deep write buffer; oldest burst retires into the array
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      buf0   <= '0;
      buf1   <= '0;
      retire <= '0;
    end else if (wr_p3) begin
      buf0   <= buf1;
      buf1   <= incoming;
      retire <= buf0;
    end else begin
      retire.valid <= 1'b0;
    end
  end

  bds_row_mem u_mem (
    .clock   (clock),
    .rd_en   (rd_acc),
    .rd_addr (addr_eff),
    .rd_row  (mem_row),
    .wr_en   (wr_p3 && buf0.valid),
    .wr_addr (buf0.addr),
    .wr_row  (buf0.data),
    .wr_lane (buf0.lane_en)
  );

  // newest data wins: array, then retiring, then buffers, then the burst closing now
  assign merged_row = merge_entry(merge_entry(merge_entry(merge_entry(mem_row, retire,
                        rd_addr_q), buf0, rd_addr_q), buf1, rd_addr_q),
                        incoming, rd_addr_q);

  // read row held until the next read; old words still leave first
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rd_row <= '0;
    end else if (rd_p1) begin
      rd_row <= merged_row;
    end
  end

  // hand-off to the output-clock side; row frozen while a request is open
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      xfer_row <= '0;
      xfer_req <= 1'b0;
    end else if (rd_p1 && !single_clock_mode && xfer_req == ack_s2) begin
      xfer_row <= merged_row;
      xfer_req <= ~xfer_req;
    end
  end

  // words two and four launched on true-clock rising edges
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      k_pos <= '0;
    end else if (rd_p2) begin
      k_pos <= '{data: rd_row[1*DATA_W +: DATA_W], valid: 1'b1};
    end else if (rd_p3) begin
      k_pos <= '{data: rd_row[3*DATA_W +: DATA_W], valid: 1'b1};
    end else begin
      k_pos.valid <= 1'b0;
    end
  end

  // words one and three launched on the complement edge, 1.5 cycles in
  always_ff @(negedge clock) begin
    if (!rst_b) begin
      k_neg <= '0;
    end else if (rd_p2) begin
      k_neg <= '{data: rd_row[0 +: DATA_W], valid: 1'b1};
    end else if (rd_p3) begin
      k_neg <= '{data: rd_row[2*DATA_W +: DATA_W], valid: 1'b1};
    end else begin
      k_neg.valid <= 1'b0;
    end
  end

  // output clock seen from the core side, plus the ack coming back
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      oc_s1  <= RST_PIN_HIGH; // parked level, so no false toggle after reset
      oc_s2  <= RST_PIN_HIGH;
      oc_s3  <= RST_PIN_HIGH;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      oc_s1  <= out_clock;
      oc_s2  <= oc_s1;
      oc_s3  <= oc_s2;
      ack_s1 <= c_ack;
      ack_s2 <= ack_s1;
    end
  end

  // output clocks parked high long enough select input-clock timing
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      hold_cnt          <= '0;
      single_clock_mode <= RST_SINGLE_MODE;
    end else begin
      // mode moves only on a seen toggle or a full hold, never while counting
      if (oc_s2 != oc_s3) begin
        hold_cnt          <= '0;
        single_clock_mode <= 1'b0;
      end else if (hold_cnt != HOLD_CNT_MAX) begin
        hold_cnt <= hold_cnt + 1'b1;
      end else begin
        single_clock_mode <= oc_s3;
      end
    end
  end

  // loop lock timer; a low disable pin bypasses the loop outright
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      doff_s1    <= RST_PIN_HIGH; // loop enabled level avoids a bypass pulse
      doff_s2    <= RST_PIN_HIGH;
      lock_cnt   <= '0;
      dll_locked <= 1'b0;
      dll_bypass <= 1'b0;
    end else begin
      doff_s1    <= dll_off_n;
      doff_s2    <= doff_s1;
      dll_bypass <= !doff_s2;
      if (!doff_s2) begin
        lock_cnt   <= '0;
        dll_locked <= 1'b0;
      end else if (lock_cnt != LOCK_CNT_MAX) begin
        lock_cnt <= lock_cnt + 1'b1;
      end else begin
        dll_locked <= 1'b1;
      end
    end
  end

  // output-clock domain: reset and request sync
  always_ff @(posedge out_clock) begin
    crst_s1 <= rst_b;
    c_rst_b <= crst_s1;
    req_s1  <= xfer_req;
    req_s2  <= req_s1;
  end

  // a stopped output clock simply freezes the sequence where it stands
  always_ff @(posedge out_clock) begin
    if (!c_rst_b) begin
      c_state <= BDS_C_IDLE;
      c_ack   <= 1'b0;
      c_row   <= '0;
      c_pos   <= '0;
    end else begin
      case (c_state)
        BDS_C_IDLE: begin
          c_pos.valid <= 1'b0;
          if (req_s2 != c_ack) begin
            c_row   <= xfer_row;
            c_ack   <= req_s2;
            c_state <= BDS_C_FIRST;
          end
        end
        BDS_C_FIRST: begin
          c_pos   <= '{data: c_row[1*DATA_W +: DATA_W], valid: 1'b1};
          c_state <= BDS_C_SECOND;
        end
        BDS_C_SECOND: begin
          c_pos   <= '{data: c_row[3*DATA_W +: DATA_W], valid: 1'b1};
          c_state <= BDS_C_IDLE;
        end
        default: begin
          c_state <= BDS_C_IDLE;
        end
      endcase
    end
  end

  // words one and three on the complement output-clock edge
  always_ff @(negedge out_clock) begin
    if (!c_rst_b) begin
      c_neg <= '0;
    end else if (c_state == BDS_C_FIRST) begin
      c_neg <= '{data: c_row[0 +: DATA_W], valid: 1'b1};
    end else if (c_state == BDS_C_SECOND) begin
      c_neg <= '{data: c_row[2*DATA_W +: DATA_W], valid: 1'b1};
    end else begin
      c_neg.valid <= 1'b0;
    end
  end

  // pick the launching register by the timing clock's current phase
  always_comb begin
    if (single_clock_mode) begin
      beat = clock ? k_pos : k_neg;
    end else begin
      beat = out_clock ? c_pos : c_neg;
    end
  end

  assign read_data     = beat.data;
  assign read_valid    = beat.valid;
  // echo pair edges coincide with the data launching edges
  assign echo_strobe   = single_clock_mode ? clock : out_clock;
  assign echo_strobe_n = ~echo_strobe;

endmodule
`default_nettype wire

// File: testbench/bds_sram_chk.sv
// Purpose: port checks for the burst sram core
// Assumes: read timing checks apply in single-clock mode only
// Notes:   loop checks leave room for the two-flop input sync
`timescale 1ns/1ps
`default_nettype none
module bds_sram_chk
  import bds_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // read side
  input wire logic read_n,
  input wire logic read_valid,
  input wire logic echo_strobe,
  input wire logic echo_strobe_n,
  // loop and mode
  input wire logic dll_off_n,
  input wire logic dll_locked,
  input wire logic dll_bypass,
  input wire logic single_clock_mode
);
  logic        rd_prev;
  logic [10:0] hi_cnt;
  wire         rd_acc = !read_n && !rd_prev;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // a read right after a taken read is dropped
  always_ff @(posedge clock) begin
    if (!rst_b) rd_prev <= 1'b0;
    else rd_prev <= rd_acc;
  end
  // cycles with the loop enabled, saturating
  always_ff @(posedge clock) begin
    if (!rst_b || !dll_off_n) hi_cnt <= 11'h000;
    else if (hi_cnt != 11'h7ff) hi_cnt <= hi_cnt + 11'h001;
  end
  a_echo_pair_inverse: assert property (echo_strobe_n == !echo_strobe)
    else $error("echo strobes not complementary");
  a_echo_single_clock: assert property ($past(single_clock_mode) && single_clock_mode
    |-> !echo_strobe)
    else $error("echo strobe not on input clock");
  a_read_first_word: assert property (rd_acc && single_clock_mode
    |-> ##2 read_valid ##1 read_valid)
    else $error("read burst late or cut short");
  a_no_spurious_valid: assert property (single_clock_mode && $rose(read_valid)
    |-> $past(rd_acc, 2))
    else $error("read data without a taken read");
  a_burst_ends: assert property (single_clock_mode && rd_acc ##2 !rd_acc
    |-> ##2 !read_valid)
    else $error("read burst longer than four words");
  a_bypass_follows: assert property (!dll_off_n [*4] |=> dll_bypass)
    else $error("loop not bypassed");
  a_bypass_clears: assert property (dll_off_n [*4] |=> !dll_bypass)
    else $error("loop bypass stuck");
  a_lock_after_count: assert property (hi_cnt >= 11'h410 |-> dll_locked)
    else $error("loop lock missing");
  a_reset_values: assert property ($rose(rst_b)
    |-> !read_valid && single_clock_mode && !dll_locked && !dll_bypass)
    else $error("wrong values after reset");
  cover property (rd_acc && single_clock_mode);
  cover property (read_valid && !single_clock_mode);
  cover property ($rose(dll_locked));
  cover property ($rose(dll_bypass));
endmodule
bind bds_sram bds_sram_chk i_bds_sram_chk (.clock, .rst_b, .read_n, .read_valid,
  .echo_strobe, .echo_strobe_n, .dll_off_n, .dll_locked, .dll_bypass, .single_clock_mode);
`default_nettype wire

// File: testbench/bds_ctrl_model.sv
// Purpose: memory controller model for read and late-write bursts
// Assumes: one command slot per clock rise, write beats on both edges
// Notes:   idle lines carry the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module bds_ctrl_model
  import bds_pkg::*;
(
  // clock
  input  wire logic                  clock,
  // commands
  output var  logic                  read_n,
  output var  logic                  write_n,
  output var  logic [ADDR_W-1:0]     burst_base_address,
  // write data
  output var  logic [LANES-1:0]      byte_lane_enable_n,
  output var  logic [DATA_W-1:0]     write_data
);
  typedef struct packed {
    logic                                   rd_n;
    logic                                   wr_n;
    logic                                   send;
    logic [ADDR_W-1:0]                      addr;
    logic [BURST_LEN-1:0][LANES+DATA_W-1:0] beats;
  } bds_cmd_t;
  bds_cmd_t                cmd_q [$];
  logic [LANES+DATA_W:0]   beat_q [$];
  logic [LANES+DATA_W:0]   bt;
  bds_cmd_t                c;
  // quiet lines at time zero
  initial begin
    read_n = 1'b1;
    write_n = 1'b1;
    burst_base_address = '0;
    {byte_lane_enable_n, write_data} = '0;
  end
  task automatic put(input logic rd_n, input logic wr_n, input logic send,
                     input logic [ADDR_W-1:0] a, input logic [BURST_LEN*(LANES+DATA_W)-1:0] b);
    cmd_q.push_back({rd_n, wr_n, send, a, b});
  endtask
  // two slots lead a lone burst, so word0 stands at rise t+1; top bit marks idle
  always @(clock) begin
    #1;
    bt = (beat_q.size() > 0) ? beat_q.pop_front() : {1'b1, {(LANES+DATA_W){1'b0}}};
    if (bt[LANES+DATA_W]) {byte_lane_enable_n, write_data} = ~{byte_lane_enable_n, write_data};
    else {byte_lane_enable_n, write_data} = bt[LANES+DATA_W-1:0];
    if (clock) begin
      if (cmd_q.size() > 0) c = cmd_q.pop_front();
      else c = {3'b110, burst_base_address, c.beats};
      read_n = c.rd_n;
      write_n = c.wr_n;
      burst_base_address = (c.rd_n && c.wr_n) ? ~burst_base_address : c.addr;
      if (!c.wr_n && c.send) begin
        while (beat_q.size() < 2) beat_q.push_back({1'b1, {(LANES+DATA_W){1'b0}}});
        for (int k = 0; k < BURST_LEN; k++) beat_q.push_back({1'b0, c.beats[k]});
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/bds_sram_tb.sv
// Purpose: self-checking bench for the burst sram core
// Assumes: the controller model paces commands; echo strobes time capture
// Notes:   reads only touch words written earlier in the run
`timescale 1ns/1ps
`default_nettype none
module bds_sram_tb
  import bds_pkg::*;
;
  localparam int BW = LANES + DATA_W;
  logic              clock = 1'b0;
  logic              rst_b = 1'b0;
  logic              out_clock = 1'b1;
  logic              dll_off_n = 1'b1;
  logic              oc_run = 1'b0;
  logic              read_n, write_n, read_valid, echo_strobe, echo_strobe_n;
  logic              dll_locked, dll_bypass, single_clock_mode;
  logic [ADDR_W-1:0] burst_base_address;
  logic [LANES-1:0]  byte_lane_enable_n;
  logic [DATA_W-1:0] write_data, read_data;
  logic [DATA_W-1:0] ref_mem [int];
  logic [DATA_W-1:0] exp_q [$];
  int                fails = 0, checks = 0, cyc = 0, n = 0, seed = 68208;
  int                addr [6];
  bds_sram i_bds_sram (.clock, .rst_b, .out_clock, .read_n, .write_n, .burst_base_address,
    .byte_lane_enable_n, .write_data, .read_data, .read_valid, .echo_strobe, .echo_strobe_n,
    .dll_off_n, .dll_locked, .dll_bypass, .single_clock_mode);
  bds_ctrl_model i_bds_ctrl_model (.clock, .read_n, .write_n, .burst_base_address,
    .byte_lane_enable_n, .write_data);
  always #5 clock = ~clock;
  // output timing clock, free running once started, phase unrelated
  initial begin
    wait (oc_run);
    #3;
    forever #40 out_clock = ~out_clock;
  end
  // hang guard
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp_word(input string what, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_flag(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask
  // queue a write; the reference copy honours the lane enables
  task automatic wr(input int a, input bit full, input bit send = 1'b1);
    logic [BURST_LEN*BW-1:0] b;
    logic [LANES-1:0]        ln;
    logic [DATA_W-1:0]       d;
    for (int k = 0; k < BURST_LEN; k++) begin
      d = DATA_W'({$random(seed), $random(seed)});
      ln = full ? 4'h0 : 4'($random(seed));
      b[k*BW +: BW] = {ln, d};
      for (int m = 0; m < LANES; m++)
        if (send && !ln[m]) ref_mem[a*4+k][m*LANE_W +: LANE_W] = d[m*LANE_W +: LANE_W];
    end
    i_bds_ctrl_model.put(1'b1, 1'b0, send, ADDR_W'(a), b);
  endtask
  task automatic rd(input int a, input bit want = 1'b1, input logic wr_n = 1'b1);
    if (want)
      for (int k = 0; k < BURST_LEN; k++) exp_q.push_back(ref_mem[a*4+k]);
    i_bds_ctrl_model.put(1'b0, wr_n, 1'b0, ADDR_W'(a), '0);
  endtask
  task automatic nop(input int cnt = 1);
    repeat (cnt) i_bds_ctrl_model.put(1'b1, 1'b1, 1'b0, '0, '0);
  endtask
  task automatic drain(input string name);
    n = 0;
    while ((i_bds_ctrl_model.cmd_q.size() > 0 || exp_q.size() > 0) && n < 400) begin
      @(posedge clock);
      n++;
    end
    repeat (4) @(posedge clock);
    cmp_flag("all words returned", 1'b1, exp_q.size() == 0);
    $display("test %s done: checks %0d fails %0d", name, checks, fails);
  endtask
  // capture on both echo strobe edges, as a controller would
  always @(echo_strobe) begin
    #2;
    cmp_flag("echo_strobe_n", ~echo_strobe, echo_strobe_n);
    if (read_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("MISMATCH read_data expected none seen %h", read_data);
      end
      else cmp_word("read_data", exp_q.pop_front(), read_data);
    end
  end
  initial begin
    repeat (4) @(posedge clock);
    #1 rst_b = 1'b1;
    wr(16, 1'b1);
    nop();
    rd(16);
    nop();
    drain("buffered read");
    foreach (addr[i]) begin
      addr[i] = {$random(seed)} % 32'h40000;
      wr(addr[i], 1'b1);
      nop();
    end
    foreach (addr[i]) begin
      rd(addr[i]);
      nop();
    end
    drain("gapless reads");
    for (int i = 0; i < 4; i++) begin
      wr(addr[i], 1'b0);
      nop();
      rd(addr[i]);
      nop();
    end
    drain("lane writes");
    wr(20, 1'b1);
    wr(20, 1'b1, 1'b0);
    nop();
    rd(20);
    rd(21, 1'b0);
    nop();
    drain("adjacent requests");
    rd(20, 1'b1, 1'b0);
    nop();
    rd(20);
    nop();
    drain("read wins");
    n = 0;
    while (dll_locked !== 1'b1 && n < 1200) begin
      @(posedge clock);
      n++;
    end
    cmp_flag("dll_locked", 1'b1, dll_locked);
    @(posedge clock) #1 dll_off_n = 1'b0;
    repeat (6) @(posedge clock);
    #1 cmp_flag("dll_bypass", 1'b1, dll_bypass);
    dll_off_n = 1'b1;
    oc_run = 1'b1;
    @(posedge clock) #1 rst_b = 1'b0;
    repeat (30) @(posedge clock);
    #1 cmp_flag("single_clock_mode", 1'b1, single_clock_mode);
    rst_b = 1'b1;
    n = 0;
    while (single_clock_mode !== 1'b0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    cmp_flag("single_clock_mode", 1'b0, single_clock_mode);
    for (int i = 0; i < 3; i++) begin
      wr(addr[i], 1'b1);
      nop();
      rd(addr[i]);
      nop(40);
    end
    drain("output clock mode");
    give_verdict();
  end
endmodule
`default_nettype wire
